/* logic/cft_pkg.sv */
`default_nettype none
package cft_pkg;
   localparam int ADR_W = 8;
   localparam logic [7:0] ADR_CTL0 = 8'h00;
   localparam logic [7:0] ADR_CTL1 = 8'h04;
   localparam logic [7:0] ADR_BT0 = 8'h08;
   localparam logic [7:0] ADR_BT1 = 8'h0C;
   localparam logic [7:0] ADR_ACC = 8'h10;
   localparam logic [7:0] ADR_STAT = 8'h14;
   localparam logic [7:0] ADR_TXTS = 8'h18;
   localparam logic [7:0] ADR_RXTS = 8'h1C;
   localparam logic [7:0] ADR_ERR = 8'h20;
   localparam logic [7:0] ADR_CODE = 8'h40;
   localparam logic [7:0] ADR_MASK = 8'h60;
   localparam logic [7:0] ADR_ARR_MSK = 8'hE3;
   // control_zero fields
   localparam int C0_INIT_REQUEST = 0;
   localparam int C0_TIME = 1;
   // control_one fields
   localparam int C1_INIT_ACKNOWLEDGE = 0;
   localparam int C1_CLOCK_SOURCE_SELECT = 6;
   localparam int C1_ENABLE = 7;
   // acceptance_control fields
   localparam int ACC_MODE_LO = 4;
   localparam int STAT_RXF = 0;
   localparam logic [7:0] RST_CTL0 = 8'h01;
   localparam logic [7:0] RST_CTL1 = 8'h00;
   localparam logic [7:0] RST_BT = 8'h00;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam int TS_W = 16;
   localparam int ERR_W = 8;
   localparam int BRP_W = 6;
   localparam int TQ_W = 4;
   localparam logic [TQ_W-1:0] TQ_ONE = 4'h1;
   localparam logic [TQ_W-1:0] TQ_ZERO = 4'h0;
   typedef enum logic [1:0] {
      CFT_TWO32 = 2'b00,
      CFT_FOUR16 = 2'b01,
      CFT_EIGHT8 = 2'b10,
      CFT_CLOSED = 2'b11
   } cft_mode_type;
   typedef enum {
      CFT_SYNC,
      CFT_SEG1,
      CFT_SEG2
   } cft_seg_type;
endpackage
`default_nettype wire

/* logic/cft_filter.sv */
`timescale 1ns/10ps
`default_nettype none
module cft_filter (
   input wire logic [63:0] code_i,
   input wire logic [63:0] mask_i,
   input wire cft_pkg::cft_mode_type mode_i,
   input wire logic [28:0] id_i,
   input wire logic ide_i,
   input wire logic rtr_i,
   input wire logic srr_i,
   output logic hit_o,
   output logic [2:0] index_o
);
   import cft_pkg::*;
   logic [31:0] w;
   logic [31:0] care;
   logic [7:0] hits;

   // mask bit set means the bit is ignored
   function automatic logic fmatch(input logic [31:0] c, input logic [31:0] m,
                                   input logic [31:0] d, input logic [31:0] k);
      fmatch = &(~(c ^ d) | m | ~k);
   endfunction

   // identifier laid out as the four identifier bytes of a buffer
   always_comb begin
      if (ide_i) begin
         w = {id_i[28:18], srr_i, ide_i, id_i[17:0], rtr_i};
         care = 32'hFFFF_FFFF;
      end else begin
         w = {id_i[10:0], rtr_i, ide_i, 19'h0_0000};
         care = 32'hFFF8_0000;
      end
   end

   always_comb begin
      hits = 8'h00;
      unique case (mode_i)
         CFT_TWO32: begin
            for (int b = 0; b < 2; b++) begin
               hits[b] = fmatch(code_i[63-32*b -: 32], mask_i[63-32*b -: 32],
                                w, care);
            end
         end
         CFT_FOUR16: begin
            for (int f = 0; f < 4; f++) begin
               hits[f] = fmatch({code_i[63-16*f -: 16], 16'h0000},
                                {mask_i[63-16*f -: 16], 16'h0000},
                                w, {care[31:16], 16'h0000});
            end
         end
         CFT_EIGHT8: begin
            for (int f = 0; f < 8; f++) begin
               hits[f] = fmatch({code_i[63-8*f -: 8], 24'h00_0000},
                                {mask_i[63-8*f -: 8], 24'h00_0000},
                                w, 32'hFF00_0000);
            end
         end
         CFT_CLOSED: hits = 8'h00;
      endcase
   end

   // lowest matching filter wins
   always_comb begin
      index_o = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (hits[i]) begin
            index_o = i[2:0];
         end
      end
      hit_o = |hits;
   end
endmodule // cft_filter
`default_nettype wire

/* logic/cft_top.sv */
`timescale 1ns/10ps
`default_nettype none
// Function
// - received standard or extended identifiers are compared to maskable patterns
// - acceptance sets receive-full and loads the three-bit filter hit index
// - with several matching filters the lowest numbered one is reported
// - two-filter mode matches 32-bit banks; bank 0 hit 0, bank 1 hit 1
// - four-filter mode matches 16-bit halves; hits 0,1 and 2,3
// - eight-filter mode matches first 8 identifier bits; hits 0 to 7
// - closed mode never moves a message nor sets receive-full
// - error counters cannot be written by any register access
// - configuration writes work only with init request and acknowledge set
// - transmit pin goes recessive at once in power-down or init mode
// - module enable takes only the first write after reset in normal modes
// - clock source select picks oscillator or bus clock as protocol clock
// - prescaler divides protocol clock into the time quantum
// - every bit starts with a one-quantum synchronization segment
// - first time segment is programmable from 1 to 16 quanta
// - second time segment is programmable from 1 to 8 quanta
// - resynchronization jump width is programmable from 1 to 4 quanta
// - new bits are driven at transmit point, sampled at sample point
// - each segment field holds the length in quanta minus one
// - with stamping on, timer is captured at end of accepted received frames and of transmitted frames
// - receive-full is set only for a correct frame that passed the filter
module cft_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [cft_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic special_mode_i,
   input wire logic power_down_i,
   input wire logic osc_tick_i,
   input wire logic rx_pin_i,
   input wire logic tx_bit_i,
   output logic tx_pin_o,
   output logic tq_tick_o,
   output logic sample_point_o,
   output logic transmit_point_o,
   output logic rx_bit_o,
   input wire logic frame_ok_i,
   input wire logic frame_tx_i,
   input wire logic [28:0] rx_id_i,
   input wire logic rx_ide_i,
   input wire logic rx_rtr_i,
   input wire logic rx_srr_i,
   input wire logic [cft_pkg::TS_W-1:0] timer_i,
   input wire logic [cft_pkg::ERR_W-1:0] rx_err_cnt_i,
   input wire logic [cft_pkg::ERR_W-1:0] tx_err_cnt_i,
   output logic rx_move_o,
   output logic rx_full_flag_o,
   output logic [2:0] filter_hit_index_o
);
   import cft_pkg::*;
   logic ack_q;
   logic [31:0] rdat_q;
   logic [7:0] control_zero_q;
   logic [7:0] control_one_q;
   logic [7:0] bit_timing_zero_q;
   logic [7:0] bit_timing_one_q;
   logic [7:0] acceptance_control_q;
   logic [63:0] code_q;
   logic [63:0] mask_q;
   logic init_ack_q;
   logic enable_written_q;
   logic rx_full_q;
   logic [2:0] hit_q;
   logic move_q;
   logic [TS_W-1:0] tx_stamp_q;
   logic [TS_W-1:0] rx_stamp_q;
   logic wr;
   logic cfg_open;
   logic filt_hit;
   logic [2:0] filt_idx;
   logic accept;
   logic [7:0] wbyte;
   logic [3:0] aidx;
   logic [7:0] abyte;
   logic pclk_en;
   logic [BRP_W-1:0] pre_q;
   logic tq;
   logic running;
   cft_seg_type seg_q;
   logic [TQ_W:0] cnt_q;
   logic [TQ_W:0] seg1_end_q;
   logic rx_prev_q;
   logic fall;
   logic [2:0] smp_q;
   logic rx_bit_q;
   logic tx_bit_q;
   logic samp_q;
   logic xmit_q;
   logic [TQ_W-1:0] sjw_len;
   logic [TQ_W-1:0] seg2_len;
   logic [TQ_W:0] seg1_len;
   logic seg1_done;
   logic seg2_done;

   function automatic logic [3:0] fbyte_index(input logic [ADR_W-1:0] a);
      fbyte_index = {a[4], a[3], a[2], 1'b0} >> 1;
   endfunction

   function automatic logic [63:0] fput(input logic [63:0] v,
                                        input logic [2:0] i,
                                        input logic [7:0] b);
      logic [63:0] r;
      r = v;
      r[63-8*i -: 8] = b;
      fput = r;
   endfunction

   function automatic logic [TQ_W:0] fnext(input logic [TQ_W:0] c);
      fnext = c + {1'b0, TQ_ONE};
   endfunction

   // fields stored minus one, so the length is the field plus one
   assign sjw_len = {2'b00, bit_timing_zero_q[7:6]} + TQ_ONE;
   assign seg1_len = {1'b0, bit_timing_one_q[3:0]} + 5'h01;
   assign seg2_len = {1'b0, bit_timing_one_q[6:4]} + TQ_ONE;

   // ---------------- wishbone slave ----------------
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];
   assign wbyte = wb_dat_i[7:0];
   assign cfg_open = control_zero_q[C0_INIT_REQUEST] & init_ack_q;
   assign aidx = fbyte_index(wb_adr_i);
   assign abyte = {wb_adr_i[ADR_W-1:5], 5'h00} & ADR_ARR_MSK;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
      end
   end

   // unmapped offsets read zero; error counters only read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_q <= 32'h0000_0000;
      end else if (wb_cyc_i & wb_stb_i & ~ack_q) begin
         rdat_q <= 32'h0000_0000;
         unique case (wb_adr_i)
            ADR_CTL0: rdat_q[7:0] <= control_zero_q;
            ADR_CTL1: rdat_q[7:0] <= {control_one_q[7:1], init_ack_q};
            ADR_BT0: rdat_q[7:0] <= bit_timing_zero_q;
            ADR_BT1: rdat_q[7:0] <= bit_timing_one_q;
            ADR_ACC: rdat_q[7:0] <= {acceptance_control_q[7:3], hit_q};
            ADR_STAT: rdat_q[STAT_RXF] <= rx_full_q;
            ADR_TXTS: rdat_q[TS_W-1:0] <= tx_stamp_q;
            ADR_RXTS: rdat_q[TS_W-1:0] <= rx_stamp_q;
            ADR_ERR: rdat_q[15:0] <= {tx_err_cnt_i, rx_err_cnt_i};
            default: begin
               if (abyte == ADR_CODE) begin
                  rdat_q[7:0] <= code_q[63-8*aidx[2:0] -: 8];
               end else if (abyte == ADR_MASK) begin
                  rdat_q[7:0] <= mask_q[63-8*aidx[2:0] -: 8];
               end
            end
         endcase
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         control_zero_q <= RST_CTL0;
      end else if (wr && wb_adr_i == ADR_CTL0) begin
         control_zero_q <= wbyte;
      end
   end

   // acknowledge follows the request one cycle later
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         init_ack_q <= 1'b0;
      end else begin
         init_ack_q <= control_zero_q[C0_INIT_REQUEST];
      end
   end

   // enable is write-once outside special mode so a stray store cannot take the node off the bus
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         control_one_q <= RST_CTL1;
         enable_written_q <= 1'b0;
      end else if (wr && wb_adr_i == ADR_CTL1 && cfg_open) begin
         if (~enable_written_q | special_mode_i) begin
            control_one_q[C1_ENABLE] <= wbyte[C1_ENABLE];
         end
         enable_written_q <= 1'b1;
         control_one_q[6:0] <= {wbyte[6:1], 1'b0};
      end
   end

   // the error counters have no write path at all
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bit_timing_zero_q <= RST_BT;
         bit_timing_one_q <= RST_BT;
         acceptance_control_q <= RST_BYTE;
         code_q <= 64'h0000_0000_0000_0000;
         mask_q <= 64'h0000_0000_0000_0000;
      end else if (wr & cfg_open) begin
         if (wb_adr_i == ADR_BT0) begin
            bit_timing_zero_q <= wbyte;
         end
         if (wb_adr_i == ADR_BT1) begin
            bit_timing_one_q <= wbyte;
         end
         if (wb_adr_i == ADR_ACC) begin
            acceptance_control_q <= {2'b00, wbyte[5:4], 4'h0};
         end
         if (abyte == ADR_CODE) begin
            code_q <= fput(code_q, aidx[2:0], wbyte);
         end
         if (abyte == ADR_MASK) begin
            mask_q <= fput(mask_q, aidx[2:0], wbyte);
         end
      end
   end

   // ---------------- acceptance ----------------
   cft_filter u_filter (
      .code_i(code_q),
      .mask_i(mask_q),
      .mode_i(cft_mode_type'(acceptance_control_q[ACC_MODE_LO +: 2])),
      .id_i(rx_id_i),
      .ide_i(rx_ide_i),
      .rtr_i(rx_rtr_i),
      .srr_i(rx_srr_i),
      .hit_o(filt_hit),
      .index_o(filt_idx)
   );

   // a frame only moves when foreground is free
   assign accept = frame_ok_i & filt_hit & ~rx_full_q;

   // set wins over a same-cycle software clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_full_q <= 1'b0;
      end else if (accept) begin
         rx_full_q <= 1'b1;
      end else if (wr && wb_adr_i == ADR_STAT && wbyte[STAT_RXF]) begin
         rx_full_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hit_q <= 3'h0;
         move_q <= 1'b0;
      end else begin
         move_q <= accept;
         if (accept) begin
            hit_q <= filt_idx;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_stamp_q <= 16'h0000;
         tx_stamp_q <= 16'h0000;
      end else if (control_zero_q[C0_TIME]) begin
         if (accept) begin
            rx_stamp_q <= timer_i;
         end
         if (frame_tx_i) begin
            tx_stamp_q <= timer_i;
         end
      end
   end
   assign rx_move_o = move_q;
   assign rx_full_flag_o = rx_full_q;
   assign filter_hit_index_o = hit_q;

   // ---------------- bit timing ----------------
   // bus clock runs every cycle; oscillator arrives as an enable
   assign pclk_en = control_one_q[C1_CLOCK_SOURCE_SELECT] | osc_tick_i;
   assign running = control_one_q[C1_ENABLE] & ~init_ack_q & ~power_down_i;
   assign tq = pclk_en && pre_q == bit_timing_zero_q[5:0];
   assign fall = rx_prev_q & ~rx_pin_i;
   assign seg1_done = seg_q == CFT_SEG1 && fnext(cnt_q) >= seg1_end_q;
   // an early fall ends segment two once the remaining part fits the jump
   assign seg2_done = seg_q == CFT_SEG2 &&
                      (fnext(cnt_q) >= {1'b0, seg2_len} ||
                       (fall && {1'b0, seg2_len} - cnt_q <= {1'b0, sjw_len}));

   always_ff @(posedge clk_i) begin
      if (rst_i || !running) begin
         pre_q <= 6'h00;
      end else if (tq) begin
         pre_q <= 6'h00;
      end else if (pclk_en) begin
         pre_q <= pre_q + 6'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_prev_q <= 1'b1;
      end else begin
         rx_prev_q <= rx_pin_i;
      end
   end

   // resync stretches segment one or cuts segment two by at most the jump
   // count is one bit wider so a stretched 16-quantum segment still ends
   always_ff @(posedge clk_i) begin
      if (rst_i || !running) begin
         seg_q <= CFT_SYNC;
         cnt_q <= {1'b0, TQ_ZERO};
         seg1_end_q <= 5'h00;
         samp_q <= 1'b0;
         xmit_q <= 1'b0;
      end else begin
         samp_q <= 1'b0;
         xmit_q <= 1'b0;
         if (fall && seg_q == CFT_SEG1) begin
            seg1_end_q <= seg1_len + ((fnext(cnt_q) < {1'b0, sjw_len}) ?
                          fnext(cnt_q) : {1'b0, sjw_len});
         end
         if (tq) begin
            unique case (seg_q)
               CFT_SYNC: begin
                  seg_q <= CFT_SEG1;
                  cnt_q <= {1'b0, TQ_ZERO};
                  seg1_end_q <= seg1_len;
               end
               CFT_SEG1: begin
                  if (seg1_done) begin
                     seg_q <= CFT_SEG2;
                     cnt_q <= {1'b0, TQ_ZERO};
                     samp_q <= 1'b1;
                  end else begin
                     cnt_q <= fnext(cnt_q);
                  end
               end
               CFT_SEG2: begin
                  if (seg2_done) begin
                     seg_q <= CFT_SYNC;
                     cnt_q <= {1'b0, TQ_ZERO};
                     xmit_q <= 1'b1;
                  end else begin
                     cnt_q <= fnext(cnt_q);
                  end
               end
            endcase
         end
      end
   end

   // triple sampling takes a majority of the last three quanta
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         smp_q <= 3'b111;
         rx_bit_q <= 1'b1;
      end else if (tq) begin
         smp_q <= {smp_q[1:0], rx_pin_i};
         if (seg1_done) begin
            rx_bit_q <= bit_timing_one_q[7] ?
                        (smp_q[1] & smp_q[0]) | (smp_q[1] & rx_pin_i) |
                        (smp_q[0] & rx_pin_i) : rx_pin_i;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !running) begin
         tx_bit_q <= 1'b1;
      end else if (tq && seg2_done) begin
         tx_bit_q <= tx_bit_i;
      end
   end

   // gated straight from the mode bits so no extra cycle of dominant leaks
   assign tx_pin_o = tx_bit_q | control_zero_q[C0_INIT_REQUEST] |
                     init_ack_q | power_down_i;
   assign tq_tick_o = tq;
   assign sample_point_o = samp_q;
   assign transmit_point_o = xmit_q;
   assign rx_bit_o = rx_bit_q;

   // ---------------- checks ----------------
   a_closed_no_move: assert property (@(posedge clk_i) disable iff (rst_i)
      acceptance_control_q[5:4] == 2'b11 |-> !accept)
      else $error("closed filter accepted a frame");
   a_full_needs_hit: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(rx_full_q) |-> $past(frame_ok_i) && $past(filt_hit))
      else $error("receive full without accepted frame");
   a_hit_index_load: assert property (@(posedge clk_i) disable iff (rst_i)
      accept |=> hit_q == $past(filt_idx) && rx_full_q)
      else $error("hit index not loaded");
   a_cfg_locked: assert property (@(posedge clk_i) disable iff (rst_i)
      !cfg_open |=> $stable(bit_timing_one_q) && $stable(code_q) &&
      $stable(control_one_q))
      else $error("config changed while online");
   a_tx_recessive: assert property (@(posedge clk_i) disable iff (rst_i)
      (power_down_i || control_zero_q[C0_INIT_REQUEST]) |-> tx_pin_o)
      else $error("transmit pin not recessive");
   a_enable_once: assert property (@(posedge clk_i) disable iff (rst_i)
      enable_written_q && !special_mode_i |=>
      $stable(control_one_q[C1_ENABLE]))
      else $error("module enable rewritten");
   a_sync_one_tq: assert property (@(posedge clk_i) disable iff (rst_i)
      running && tq && seg_q == CFT_SYNC |=> seg_q == CFT_SEG1)
      else $error("sync segment not one quantum");
   a_sample_then_tx: assert property (@(posedge clk_i) disable iff (rst_i)
      samp_q |-> !xmit_q && seg_q == CFT_SEG2 && cnt_q == {1'b0, TQ_ZERO}
      ##1 seg_q != CFT_SEG1)
      else $error("sample point out of place");
   a_filter_prio: assert property (@(posedge clk_i) disable iff (rst_i)
      accept && filt_idx != 3'h0 |-> !u_filter.hits[0])
      else $error("lower filter not preferred");
endmodule // cft_top
`default_nettype wire

/* sim/cft_bus_node.sv */
`timescale 1ns/10ps
`default_nettype none
// the other nodes only ever sit recessive, so the wired-and bus line
// simply follows our own transmit pin
module cft_bus_node (
   input wire logic clk_i,
   input wire logic tx_pin_i,
   output logic rx_pin_o,
   output logic frame_ok_o,
   output logic frame_tx_o,
   output logic [28:0] id_o,
   output logic ide_o,
   output logic rtr_o,
   output logic srr_o
);
   assign rx_pin_o = tx_pin_i;
   initial begin
      frame_ok_o = 1'b0;
      frame_tx_o = 1'b0;
      id_o = 29'h0000_0000;
      ide_o = 1'b0;
      rtr_o = 1'b0;
      srr_o = 1'b0;
   end
   // fields hold only for the end-of-frame cycle, then scramble
   task automatic send(input logic [28:0] id, input logic ide,
                       input logic rtr, input logic srr, input logic tx);
      frame_ok_o <= ~tx;
      frame_tx_o <= tx;
      id_o <= id;
      ide_o <= ide;
      rtr_o <= rtr;
      srr_o <= srr;
      @(posedge clk_i);
      frame_ok_o <= 1'b0;
      frame_tx_o <= 1'b0;
      id_o <= ~id;
      ide_o <= ~ide;
      rtr_o <= ~rtr;
      srr_o <= ~srr;
   endtask
endmodule // cft_bus_node
`default_nettype wire

/* sim/test_cft_top.sv */
`timescale 1ns/10ps
`default_nettype none
module test_cft_top;
   import cft_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0, power_down_i = 1'b0, osc_tick_i = 1'b0;
   logic special_mode_i = 1'b0;
   logic tx_bit_i = 1'b1, wb_ack_o, rx_pin, tx_pin_o, tq_tick_o;
   logic sample_point_o, transmit_point_o, rx_bit_o, frame_ok, frame_tx;
   logic ide, rtr, srr, rx_move_o, rx_full_flag_o;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
   logic [28:0] rx_id, e = 29'h0abc_def1;
   logic [2:0] filter_hit_index_o;
   logic [15:0] timer_i = 16'h0000;
   int fails = 0, tests_run = 0, moves = 0, accepts = 0, n, tqs;

   cft_top u_cft_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(4'h1), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .special_mode_i(special_mode_i),
      .power_down_i(power_down_i), .osc_tick_i(osc_tick_i),
      .rx_pin_i(rx_pin), .tx_bit_i(tx_bit_i), .tx_pin_o(tx_pin_o),
      .tq_tick_o(tq_tick_o), .sample_point_o(sample_point_o),
      .transmit_point_o(transmit_point_o), .rx_bit_o(rx_bit_o),
      .frame_ok_i(frame_ok), .frame_tx_i(frame_tx), .rx_id_i(rx_id),
      .rx_ide_i(ide), .rx_rtr_i(rtr), .rx_srr_i(srr), .timer_i(timer_i),
      .rx_err_cnt_i(8'h5a), .tx_err_cnt_i(8'hc3), .rx_move_o(rx_move_o),
      .rx_full_flag_o(rx_full_flag_o),
      .filter_hit_index_o(filter_hit_index_o));
   cft_bus_node u_cft_bus_node (.clk_i(clk_i), .tx_pin_i(tx_pin_o),
      .rx_pin_o(rx_pin), .frame_ok_o(frame_ok), .frame_tx_o(frame_tx),
      .id_o(rx_id), .ide_o(ide), .rtr_o(rtr), .srr_o(srr));

   always #5 clk_i = ~clk_i;
   // oscillator enable at half the bus rate, so the source choice shows
   always @(posedge clk_i) osc_tick_i <= ~osc_tick_i;
   always @(posedge clk_i) begin
      if (rx_move_o === 1'b1) moves <= moves + 1;
   end

   task automatic report_and_stop();
      if (fails == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic [7:0] a, input logic we, input logic [7:0] d);
      int k;
      k = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= {24'h00_0000, d};
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      if (k >= 20) begin
         fails++;
         report_and_stop();
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic setf(input logic [1:0] m, input logic [63:0] c,
                       input logic [63:0] k);
      wb(ADR_ACC, 1'b1, {2'h0, m, 4'h0});
      for (int i = 0; i < 8; i++) begin
         wb(ADR_CODE + 8'(4 * i), 1'b1, c[63 - 8 * i -: 8]);
         wb(ADR_MASK + 8'(4 * i), 1'b1, k[63 - 8 * i -: 8]);
      end
   endtask
   // irs = {ide, rtr, srr}
   task automatic frame(input logic [28:0] id, input logic [2:0] irs,
                        input logic ok, input logic [2:0] hit);
      u_cft_bus_node.send(id, irs[2], irs[1], irs[0], 1'b0);
      @(posedge clk_i);
      check(rx_full_flag_o, ok);
      if (ok) check(filter_hit_index_o, hit);
      accepts += int'(ok);
      wb(ADR_STAT, 1'b1, 8'h01);
      check(rx_full_flag_o, 1'b0);
   endtask
   task automatic gap(input logic tp);
      n = 0;
      tqs = 0;
      do begin
         @(posedge clk_i);
         n++;
         if (tq_tick_o === 1'b1) tqs++;
      end while ((tp ? transmit_point_o : sample_point_o) !== 1'b1 && n < 200);
      if (n >= 200) begin
         fails++;
         report_and_stop();
      end
   endtask

   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check(tx_pin_o, 1'b1);
      wb(ADR_ERR, 1'b1, 8'hff);
      wb(ADR_ERR, 1'b0, 8'h00);
      check(q, 32'h0000_c35a);
      wb(ADR_CTL1, 1'b1, 8'h80);
      wb(ADR_CTL1, 1'b1, 8'h00);
      wb(ADR_CTL1, 1'b0, 8'h00);
      check(q, 32'h0000_0081);
      special_mode_i <= 1'b1;
      wb(ADR_CTL1, 1'b1, 8'h00);
      wb(ADR_CTL1, 1'b0, 8'h00);
      check(q, 32'h0000_0001);
      wb(ADR_CTL1, 1'b1, 8'h80);
      special_mode_i <= 1'b0;
      wb(ADR_CTL0, 1'b1, 8'h03);
      wb(ADR_BT0, 1'b1, 8'h41);
      wb(ADR_BT1, 1'b1, 8'h23);
      wb(ADR_BT1, 1'b0, 8'h00);
      check(q, 32'h0000_0023);
      setf(2'h2, 64'h1011_1213_1415_1617, 64'h0000_0000_0000_0000);
      timer_i <= 16'h1234;
      frame(29'h0000_0098, 3'h0, 1'b1, 3'h3);
      wb(ADR_RXTS, 1'b0, 8'h00);
      check(q, 32'h0000_1234);
      frame(29'h02c0_0000, 3'h5, 1'b1, 3'h6);
      frame(29'h0000_0100, 3'h0, 1'b0, 3'h0);
      timer_i <= 16'h4321;
      u_cft_bus_node.send(29'h0000_0000, 1'b0, 1'b0, 1'b0, 1'b1);
      wb(ADR_TXTS, 1'b0, 8'h00);
      check(q, 32'h0000_4321);
      setf(2'h1, 64'hffff_1110_b4a0_b4a0, {4{16'h0007}});
      frame(29'h0000_05a5, 3'h0, 1'b1, 3'h2);
      frame(29'h0000_05a5, 3'h2, 1'b0, 3'h0);
      setf(2'h0, {32'hffff_ffff, e[28:18], 2'h3, e[17:0], 1'b0},
           64'h0000_0000_0000_0000);
      frame(e, 3'h5, 1'b1, 3'h1);
      setf(2'h3, 64'h0000_0000_0000_0000, 64'hffff_ffff_ffff_ffff);
      frame(29'h0000_05a5, 3'h0, 1'b0, 3'h0);
      check(moves, accepts);
      wb(ADR_CTL0, 1'b1, 8'h02);
      wb(ADR_ACC, 1'b1, 8'h00);
      wb(ADR_CODE, 1'b1, 8'haa);
      wb(ADR_CTL1, 1'b1, 8'h00);
      wb(ADR_ACC, 1'b0, 8'h00);
      check(q[5:4], 2'h3);
      wb(ADR_CODE, 1'b0, 8'h00);
      check(q, 32'h0000_0000);
      wb(ADR_CTL1, 1'b0, 8'h00);
      check(q, 32'h0000_0080);
      // quantum is 2 oscillator enables, 4 bus cycles
      gap(1'b0);
      gap(1'b1);
      check(n, 12);
      check(tqs, 3);
      gap(1'b0);
      check(n, 20);
      check(tqs, 5);
      check(rx_bit_o, 1'b1);
      tx_bit_i <= 1'b0;
      gap(1'b1);
      @(posedge clk_i);
      check(tx_pin_o, 1'b0);
      power_down_i <= 1'b1;
      @(posedge clk_i);
      check(tx_pin_o, 1'b1);
      report_and_stop();
   end
endmodule // test_cft_top
`default_nettype wire
